/* File: dv/spl_ctrl_tb.sv */
// Purpose: Self-checking bench for the protection and lockdown host.
// Assumes: Zero wait state APB slave; device model busy shorter than host wait.
// Notes:   Expected maps are built here from the byte rules, not read back.
`timescale 1ns/1ps
module spl_ctrl_tb;
	import spl_pkg::*;
	logic         clk_sys = 1'b0;
	logic         sys_rst = 1'b1;
	logic         psel    = 1'b0;
	logic         penable = 1'b0;
	logic         pwrite  = 1'b0;
	logic [7:0]   paddr   = 8'h00;
	logic [31:0]  pwdata  = 32'h0;
	logic [31:0]  prdata;
	logic         pready;
	logic         pslverr;
	logic         chip_select_n;
	logic         serial_clock;
	logic         serial_in;
	logic         serial_out;
	int           fail_count  = 0;
	int           checks_done = 0;
	logic [31:0]  rd;
	logic         er;
	logic [127:0] m;
	logic [127:0] pat;
	logic [127:0] lk;
	logic [23:0]  la [3] = '{24'h050123, 24'h000010, 24'h000800};

	always #25 clk_sys = ~clk_sys;

	spl_ctrl #(.PROG_WAIT_CYC(16)) spl_ctrl_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .chip_select_n(chip_select_n),
		.serial_clock(serial_clock), .serial_in(serial_in), .serial_out(serial_out));
	spl_dev_model spl_dev_model_inst (.chip_select_n(chip_select_n),
		.serial_clock(serial_clock), .serial_in(serial_in), .serial_out(serial_out));

	// ----------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------
	task stop_test();
		if (fail_count == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : stop_test

	task check(input string nm, input logic [127:0] seen, input logic [127:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : check

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge clk_sys);
			n++;
		end
		if (n >= 50) begin
			fail_count++;
			stop_test();
		end
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task run_cmd(input logic [2:0] c);
		int n;
		n = 0;
		apb(1'b1, REG_CTRL, 32'h100 | c);
		apb(1'b0, REG_STAT, 32'h0);
		while (rd[0] !== 1'b0 && n < 3000) begin
			apb(1'b0, REG_STAT, 32'h0);
			n++;
		end
		if (n >= 3000) begin
			fail_count++;
			stop_test();
		end
	endtask : run_cmd

	task rd_map(input logic [7:0] base);
		for (int j = 0; j < 4; j++) begin
			apb(1'b0, base + 8'(4 * j), 32'h0);
			m[32*j +: 32] = rd;
		end
	endtask : rd_map

	// ----------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------
	initial begin
		pat = '0;
		pat[7:0] = 8'hF0;
		for (int i = 1; i < 16; i++) pat[8*i +: 8] = (i % 2) ? 8'hFF : 8'h00;
		repeat (10) @(posedge clk_sys);
		sys_rst <= 1'b0;
		apb(1'b0, REG_STAT, 32'h0);
		check("status reset", rd, 32'h0);
		apb(1'b0, REG_RSVD, 32'h0);
		check("unmapped err", {er, rd}, {1'b1, 32'h0});
		apb(1'b0, 8'h40, 32'h0);
		check("high err", er, 1'b1);
		// Program before any erase is refused, link untouched
		run_cmd(SPL_CMD_PROG);
		check("no erase err", {rd[3:2], chip_select_n}, 3'b011);
		apb(1'b1, REG_STAT, 32'h6);
		run_cmd(SPL_CMD_ERASE);
		check("erase status", {rd[31:16], rd[3:1]}, {16'h1, 3'b101});
		run_cmd(SPL_CMD_RDPROT);
		rd_map(8'h20);
		check("erased map", m, {128{1'b1}});
		// Non 00/FF byte refused
		apb(1'b1, REG_STAT, 32'h6);
		apb(1'b1, 8'h10, 32'h000017F0);
		run_cmd(SPL_CMD_PROG);
		check("bad byte err", rd[2], 1'b1);
		apb(1'b1, REG_STAT, 32'h6);
		for (int j = 0; j < 4; j++) apb(1'b1, 8'h10 + 8'(4 * j), pat[32*j +: 32]);
		apb(1'b1, REG_CTRL, 32'h100 | SPL_CMD_PROG);
		// Second start lands mid-frame and is refused; run_cmd then waits it out
		run_cmd(SPL_CMD_PROG);
		check("busy start err", {rd[31:16], rd[2]}, {16'h2, 1'b1});
		run_cmd(SPL_CMD_RDPROT);
		rd_map(8'h20);
		check("prot map", m, pat);
		lk = '0;
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, REG_ADDR, {8'h00, la[i]});
			run_cmd(SPL_CMD_LOCK);
		end
		lk[47:40] = 8'hFF;
		lk[7:0]   = 8'hF0;
		run_cmd(SPL_CMD_RDLOCK);
		rd_map(8'h30);
		check("lock map", m, lk);
		apb(1'b1, REG_STAT, 32'h6);
		apb(1'b1, REG_CTRL, 32'h105);
		apb(1'b0, REG_STAT, 32'h0);
		check("bad cmd err", {rd[2], chip_select_n}, 2'b11);
		stop_test();
	end
endmodule : spl_ctrl_tb

/* File: dv/spl_dev_model.sv */
// Purpose: Behavioural flash device answering protect and lockdown frames.
// Assumes: Mode 0 link; host samples serial_out on rising serial_clock.
// Notes:   Released serial_out flips level, so no stale bit passes as data.
`timescale 1ns/1ps
module spl_dev_model #(
	parameter int BUSY_NS = 600
) (
	input  wire logic chip_select_n,
	input  wire logic serial_clock,
	input  wire logic serial_in,
	output      logic serial_out
);
	logic [7:0] prot [16];
	logic [7:0] lock [16];
	logic [7:0] buf1 [16];
	logic [7:0] hdr  [7];
	logic [7:0] sh;
	logic       busy;
	int         cnt;
	int         k;
	logic [7:0] b;

	initial begin
		for (int i = 0; i < 16; i++) begin
			prot[i] = 8'h00;
			lock[i] = 8'h00;
		end
		busy       = 1'b0;
		serial_out = 1'b0;
		cnt        = 0;
	end

	function automatic logic pfx();
		pfx = hdr[0] == 8'h3D && hdr[1] == 8'h2A && hdr[2] == 8'h7F;
	endfunction : pfx

	always @(negedge chip_select_n) cnt = 0;

	// ----------------------------------------------------------
	// Byte capture, MSB first on rising clock
	// ----------------------------------------------------------
	always @(posedge serial_clock) begin
		if (!chip_select_n) begin
			sh = {sh[6:0], serial_in};
			cnt++;
			if (cnt % 8 == 0) begin
				k = cnt / 8 - 1;
				if (k < 7) hdr[k] = sh;
				if (k >= 4 && pfx() && hdr[3] == 8'hFC && !busy) begin
					buf1[(k - 4) % 16] = sh;
				end
			end
		end
	end

	// ----------------------------------------------------------
	// Read data out, changed on falling clock
	// ----------------------------------------------------------
	always @(negedge serial_clock) begin
		if (!chip_select_n && !busy && cnt >= 32 && (hdr[0] == 8'h32 || hdr[0] == 8'h35)) begin
			k = (cnt - 32) / 8;
			if (k < 16) begin
				b          = (hdr[0] == 8'h32) ? prot[k] : lock[k];
				serial_out = b[7 - cnt % 8];
			end else begin
				serial_out = ~serial_out;
			end
		end
	end

	// Frame end: release output, commit self-timed work
	always @(posedge chip_select_n) begin
		serial_out = ~serial_out;
		if (!busy && pfx() && cnt >= 32) begin
			if (hdr[3] == 8'hFC) begin
				for (int i = 0; i < 16; i++) prot[i] = buf1[i];
			end else if (hdr[3] == 8'hCF) begin
				for (int i = 0; i < 16; i++) prot[i] = 8'hFF;
			end else if (hdr[3] == 8'h30 && cnt == 56) begin
				// Bits only ever set: no unlock path
				if (hdr[4][3:0] != 4'h0) lock[hdr[4][3:0]] = 8'hFF;
				else if (hdr[5][7:3] == 5'h00) lock[0] = lock[0] | 8'hC0;
				else lock[0] = lock[0] | 8'h30;
			end
			busy = 1'b1;
			busy <= #(BUSY_NS) 1'b0;
		end
	end
endmodule : spl_dev_model

/* File: hdl/spl_ctrl.sv */
// Purpose: APB-driven host for protection and lockdown register commands.
// Assumes: Device answers on serial_out; link clock is made here.
// Notes:   Busy time after a write frame is a fixed wait, no status poll.
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
module spl_ctrl #(
	parameter int PROGRAM_TIME_NS = 5000000,
	parameter int PROG_WAIT_CYC   = (PROGRAM_TIME_NS + spl_pkg::CLK_PERIOD_NS - 1)
	                                / spl_pkg::CLK_PERIOD_NS
) (
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output      logic [31:0] prdata,
	output      logic        pready,
	output      logic        pslverr,
	output      logic        chip_select_n,
	output      logic        serial_clock,
	output      logic        serial_in,
	input  wire logic        serial_out
);
	import spl_pkg::*;

	localparam logic [23:0] WAIT_LONG  = 24'(PROG_WAIT_CYC - 1);
	localparam logic [23:0] WAIT_SHORT = {20'h00000, HALF_M1};

	spl_shift_if sh_if ();

	spl_state_t   state;
	logic [2:0]   cmd_q;
	logic [4:0]   idx;
	logic [3:0]   gap;
	logic [23:0]  wcnt;
	logic [127:0] wvec;
	logic [127:0] prot_map;
	logic [127:0] lock_map;
	logic [23:0]  lock_addr;
	logic [15:0]  cyc_cnt;
	logic         erased;
	logic         done_f;
	logic         err;

	// --------------------------------------------------------------
	// APB decode
	// --------------------------------------------------------------
	wire        setup_ph = psel & ~penable;
	wire        wr       = psel & penable & pwrite;
	wire [1:0]  grp      = paddr[5:4];
	wire [1:0]  wsel     = paddr[3:2];
	wire        mapped   = (paddr[1:0] == 2'b00) && (paddr[7:6] == 2'b00)
	                       && (paddr != REG_RSVD);
	wire        busy     = (state != ST_IDLE);
	wire        wr_stat  = wr && (paddr == REG_STAT);
	wire        wr_free  = wr && !busy;
	wire [2:0]  req_cmd  = pwdata[2:0];
	wire        start_rq = wr && (paddr == REG_CTRL) && pwdata[CTRL_START];

	// Refuse rather than send a frame the device would mishandle
	wire bad_code = (req_cmd > SPL_CMD_ERASE);
	wire bad_prog = (req_cmd == SPL_CMD_PROG) && !erased;
	wire bad_data = (req_cmd == SPL_CMD_PROG) && !bytes_ok(wvec);
	wire bad_wear = ((req_cmd == SPL_CMD_PROG) || (req_cmd == SPL_CMD_ERASE))
	                && (cyc_cnt >= CYCLE_LIMIT);
	wire req_bad  = bad_code || bad_prog || bad_data || bad_wear;
	wire go       = start_rq && !busy && !req_bad;
	wire refuse   = start_rq && (busy || req_bad);

	wire [31:0] ctrl_word = {29'h0, cmd_q};
	wire [31:0] stat_word = {cyc_cnt, 12'h000, erased, err, done_f, busy};
	wire [31:0] cfg_word  = (wsel == 2'b00) ? ctrl_word :
	                        (wsel == 2'b01) ? stat_word :
	                        {8'h00, lock_addr};
	wire [31:0] rd_word   = !mapped          ? 32'h00000000 :
	                        (grp == GRP_CFG)   ? cfg_word :
	                        (grp == GRP_WDATA) ? wvec[{wsel, 5'h00} +: 32] :
	                        (grp == GRP_PROT)  ? prot_map[{wsel, 5'h00} +: 32] :
	                        lock_map[{wsel, 5'h00} +: 32];

	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			prdata <= 32'h00000000;
		end else if (setup_ph) begin
			prdata <= rd_word;
		end
	end

	// Data and address are frozen while a frame is running
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			wvec      <= 128'h0;
			lock_addr <= 24'h000000;
		end else if (wr_free && mapped && grp == GRP_WDATA) begin
			wvec[{wsel, 5'h00} +: 32] <= pwdata;
		end else if (wr_free && paddr == REG_ADDR) begin
			lock_addr <= pwdata[23:0];
		end
	end

	// --------------------------------------------------------------
	// Frame sequencer
	// --------------------------------------------------------------
	wire        last_byte = (idx == frame_len(cmd_q) - 5'h01);
	wire [23:0] wait_lim  = is_long(cmd_q) ? WAIT_LONG : WAIT_SHORT;
	wire        frame_end = (state == ST_WAIT) && (wcnt == wait_lim);
	wire [3:0]  rx_pos    = 4'(idx - HDR_BYTES);
	wire        rx_take   = (state == ST_BYTE) && sh_if.done
	                        && is_read(cmd_q) && (idx >= HDR_BYTES);

	function automatic logic [7:0] tx_sel(input logic [2:0] c, input logic [4:0] i,
	                                      input logic [127:0] w, input logic [23:0] a);
		logic [3:0] b;
		b      = 4'(i - HDR_BYTES);
		tx_sel = OP_DUMMY;
		if (is_read(c)) begin
			if (i == 5'h00) begin
				tx_sel = (c == SPL_CMD_RDPROT) ? OP_RD_PROT : OP_RD_LOCK;
			end
		end else if (i < HDR_BYTES) begin
			case (i[1:0])
				2'b00:   tx_sel = OP_PFX0;
				2'b01:   tx_sel = OP_PFX1;
				2'b10:   tx_sel = OP_PFX2;
				default: tx_sel = (c == SPL_CMD_PROG) ? OP_PROG :
				                  (c == SPL_CMD_LOCK) ? OP_LOCK : OP_ERASE;
			endcase
		end else if (c == SPL_CMD_PROG) begin
			tx_sel = w[{b, 3'h0} +: 8];
		end else begin
			case (b)
				4'h0:    tx_sel = a[23:16];
				4'h1:    tx_sel = a[15:8];
				default: tx_sel = a[7:0];
			endcase
		end
	endfunction : tx_sel

	assign sh_if.start = (state == ST_LOAD);
	assign sh_if.tx    = tx_sel(cmd_q, idx, wvec, lock_addr);

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state         <= ST_IDLE;
			chip_select_n <= 1'b1;
			cmd_q         <= SPL_CMD_PROG;
			idx           <= 5'h00;
			gap           <= 4'h0;
			wcnt          <= 24'h000000;
		end else begin
			case (state)
				ST_IDLE: begin
					if (go) begin
						cmd_q         <= req_cmd;
						chip_select_n <= 1'b0;
						idx           <= 5'h00;
						gap           <= 4'h0;
						state         <= ST_SETUP;
					end
				end
				ST_SETUP: begin
					gap <= gap + 4'h1;
					if (gap == HALF_M1) begin
						state <= ST_LOAD;
					end
				end
				ST_LOAD: state <= ST_BYTE;
				ST_BYTE: begin
					if (sh_if.done) begin
						gap <= 4'h0;
						// Full frame every time, so no sector is left unsent
						if (last_byte) begin
							state <= ST_TAIL;
						end else begin
							idx   <= idx + 5'h01;
							state <= ST_LOAD;
						end
					end
				end
				ST_TAIL: begin
					gap <= gap + 4'h1;
					if (gap == HALF_M1) begin
						chip_select_n <= 1'b1;
						wcnt          <= 24'h000000;
						state         <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					// Hold off new frames until the device is done
					wcnt <= wcnt + 24'h000001;
					if (frame_end) begin
						state <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// Read bytes land in sector order, first byte is sector 0
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			prot_map <= 128'h0;
			lock_map <= 128'h0;
		end else if (rx_take && cmd_q == SPL_CMD_RDPROT) begin
			prot_map[{rx_pos, 3'h0} +: 8] <= sh_if.rx;
		end else if (rx_take) begin
			lock_map[{rx_pos, 3'h0} +: 8] <= sh_if.rx;
		end
	end

	// --------------------------------------------------------------
	// Status; a hardware set wins over a software clear
	// --------------------------------------------------------------
	wire wr_end = (state == ST_TAIL) && (gap == HALF_M1);
	wire wears  = (cmd_q == SPL_CMD_PROG) || (cmd_q == SPL_CMD_ERASE);

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			done_f  <= 1'b0;
			err     <= 1'b0;
			erased  <= 1'b0;
			cyc_cnt <= 16'h0000;
		end else begin
			done_f <= frame_end | (done_f & ~(wr_stat & pwdata[STAT_DONE]));
			err    <= refuse | (err & ~(wr_stat & pwdata[STAT_ERR]));
			if (wr_end && wears) begin
				erased  <= (cmd_q == SPL_CMD_ERASE);
				cyc_cnt <= cyc_cnt + 16'h0001;
			end
		end
	end

	spl_shifter spl_shifter_inst (
		.clk_sys      (clk_sys),
		.sys_rst      (sys_rst),
		.sh           (sh_if.shifter),
		.serial_clock (serial_clock),
		.serial_in    (serial_in),
		.serial_out   (serial_out)
	);

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	logic [4:0] frame_bytes;
	always_ff @(posedge clk_sys) begin
		if (sys_rst || state == ST_IDLE) begin
			frame_bytes <= 5'h00;
		end else if (sh_if.done) begin
			frame_bytes <= frame_bytes + 5'h01;
		end
	end

	property p_prog_len;
		@(posedge clk_sys) disable iff (sys_rst)
		$rose(chip_select_n) && cmd_q == SPL_CMD_PROG |-> frame_bytes == 5'h14;
	endproperty
	a_prog_len: assert property (p_prog_len) else $error("program frame not 20 bytes");

	property p_lock_len;
		@(posedge clk_sys) disable iff (sys_rst)
		$rose(chip_select_n) && cmd_q == SPL_CMD_LOCK |-> frame_bytes == 5'h07;
	endproperty
	a_lock_len: assert property (p_lock_len) else $error("lockdown frame not 7 bytes");

	property p_read_len;
		@(posedge clk_sys) disable iff (sys_rst)
		$rose(chip_select_n) && is_read(cmd_q) |-> frame_bytes == 5'h14;
	endproperty
	a_read_len: assert property (p_read_len) else $error("read frame not 20 bytes");

	property p_first_byte;
		@(posedge clk_sys) disable iff (sys_rst)
		sh_if.start && idx == 5'h00 && !is_read(cmd_q) |-> sh_if.tx == 8'h3D;
	endproperty
	a_first_byte: assert property (p_first_byte) else $error("prefix byte wrong");

	property p_busy_hold;
		@(posedge clk_sys) disable iff (sys_rst)
		$rose(chip_select_n) && is_long(cmd_q) |-> (busy && chip_select_n) [*8];
	endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("busy wait cut short");

	property p_refuse_busy;
		@(posedge clk_sys) disable iff (sys_rst)
		start_rq && busy |-> ##1 (err && $stable(cmd_q));
	endproperty
	a_refuse_busy: assert property (p_refuse_busy) else $error("start taken while busy");

	property p_data_legal;
		@(posedge clk_sys) disable iff (sys_rst)
		$fell(chip_select_n) && cmd_q == SPL_CMD_PROG |-> bytes_ok(wvec) && erased;
	endproperty
	a_data_legal: assert property (p_data_legal) else $error("illegal program frame sent");

	property p_wear;
		@(posedge clk_sys) disable iff (sys_rst)
		$fell(chip_select_n) && wears |-> cyc_cnt < CYCLE_LIMIT;
	endproperty
	a_wear: assert property (p_wear) else $error("rewrite limit exceeded");
endmodule : spl_ctrl

/* File: hdl/spl_pkg.sv */
// Purpose: Constants, command codes and helpers for the sector protection host.
// Assumes: 20 MHz system clock, SPI mode 0 link, MSB first.
// Notes:   Byte k of every 16-byte map sits in bits 8k+7:8k.
// Behaviour
// - Program frame starts 3D 2A 7F FC
// - Sixteen data bytes follow, sector 0 first
// - Chip select rise starts busy program cycle
// - Only 00 or FF data bytes allowed; sector 0 byte is checked only as bit pairs 7:6 and 5:4
// - Protect read: 32 plus three dummy bytes
// - Chip select rise ends protect read
// - Limit register rewrites to 10,000
// - Lockdown frame 3D 2A 7F 30 plus address
// - Chip select rise starts busy lockdown
// - Lock read: 35 plus three dummy bytes
// - Chip select rise ends lock read
// - After power loss, reread and relock; the host does neither, and its maps read 0 after reset
// - Erase protect register before programming
package spl_pkg;
	// --------------------------------------------------------------
	// Timing
	// --------------------------------------------------------------
	localparam int         CLK_PERIOD_NS = 50;
	localparam int         SCK_PERIOD_NS = 400;
	localparam int         HALF_CYC      = (SCK_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] HALF_M1       = 4'(HALF_CYC - 1);
	// --------------------------------------------------------------
	// Frame layout and opcodes
	// --------------------------------------------------------------
	localparam logic [4:0] HDR_BYTES = 5'h04;
	localparam logic [4:0] LEN_DATA  = 5'h14;
	localparam logic [4:0] LEN_LOCK  = 5'h07;
	localparam logic [4:0] LEN_ERASE = 5'h04;
	localparam logic [7:0] OP_PFX0     = 8'h3D;
	localparam logic [7:0] OP_PFX1     = 8'h2A;
	localparam logic [7:0] OP_PFX2     = 8'h7F;
	localparam logic [7:0] OP_PROG     = 8'hFC;
	localparam logic [7:0] OP_ERASE    = 8'hCF;
	localparam logic [7:0] OP_LOCK     = 8'h30;
	localparam logic [7:0] OP_RD_PROT  = 8'h32;
	localparam logic [7:0] OP_RD_LOCK  = 8'h35;
	localparam logic [7:0] OP_DUMMY    = 8'h00;
	localparam logic [7:0] BYTE_SET    = 8'hFF;
	localparam logic [7:0] BYTE_CLR    = 8'h00;
	localparam logic [15:0] CYCLE_LIMIT = 16'h2710;
	// --------------------------------------------------------------
	// Register map (byte addresses)
	// --------------------------------------------------------------
	localparam logic [7:0] REG_CTRL  = 8'h00;
	localparam logic [7:0] REG_STAT  = 8'h04;
	localparam logic [7:0] REG_ADDR  = 8'h08;
	localparam logic [7:0] REG_RSVD  = 8'h0C;
	localparam logic [1:0] GRP_CFG   = 2'b00;
	localparam logic [1:0] GRP_WDATA = 2'b01;
	localparam logic [1:0] GRP_PROT  = 2'b10;
	localparam int         CTRL_START = 8;
	localparam int         STAT_DONE  = 1;
	localparam int         STAT_ERR   = 2;

	typedef enum logic [2:0] {
		SPL_CMD_PROG   = 3'b000,
		SPL_CMD_RDPROT = 3'b001,
		SPL_CMD_LOCK   = 3'b010,
		SPL_CMD_RDLOCK = 3'b011,
		SPL_CMD_ERASE  = 3'b100
	} spl_cmd_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_SETUP = 3'b001,
		ST_LOAD  = 3'b010,
		ST_BYTE  = 3'b011,
		ST_TAIL  = 3'b100,
		ST_WAIT  = 3'b101
	} spl_state_t;

	function automatic logic is_read(input logic [2:0] c);
		is_read = (c == SPL_CMD_RDPROT) || (c == SPL_CMD_RDLOCK);
	endfunction : is_read

	function automatic logic is_long(input logic [2:0] c);
		is_long = (c == SPL_CMD_PROG) || (c == SPL_CMD_LOCK) || (c == SPL_CMD_ERASE);
	endfunction : is_long

	function automatic logic [4:0] frame_len(input logic [2:0] c);
		case (c)
			SPL_CMD_LOCK:  frame_len = LEN_LOCK;
			SPL_CMD_ERASE: frame_len = LEN_ERASE;
			default:       frame_len = LEN_DATA;
		endcase
	endfunction : frame_len

	function automatic logic bytes_ok(input logic [127:0] v);
		bytes_ok = 1'b1;
		for (int k = 1; k < 16; k++) begin
			if (v[8*k +: 8] != BYTE_SET && v[8*k +: 8] != BYTE_CLR) begin
				bytes_ok = 1'b0;
			end
		end
		// Sector 0 halves go in bit pairs, low nibble is ignored
		if ((v[7] ^ v[6]) || (v[5] ^ v[4])) begin
			bytes_ok = 1'b0;
		end
	endfunction : bytes_ok
endpackage : spl_pkg

/* File: hdl/spl_shift_if.sv */
// Purpose: Byte handshake between the frame sequencer and the bit shifter.
// Assumes: One clock domain.
// Notes:   start is taken only while busy is low.
`timescale 1ns/1ps
interface spl_shift_if;
	logic       start;
	logic [7:0] tx;
	logic [7:0] rx;
	logic       done;
	logic       busy;
	modport ctrl    (output start, output tx, input rx, input done, input busy);
	modport shifter (input start, input tx, output rx, output done, output busy);
endinterface : spl_shift_if

/* File: hdl/spl_shifter.sv */
// Purpose: Shifts one byte out and in on a mode 0 serial link.
// Assumes: Link data from the device changes after the falling clock edge.
// Notes:   Clock is divided from clk_sys; idles low between bytes.
`timescale 1ns/1ps
module spl_shifter (
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	spl_shift_if.shifter sh,
	output      logic serial_clock,
	output      logic serial_in,
	input  wire logic serial_out
);
	import spl_pkg::*;

	logic       so_meta;
	logic       so_sync;
	logic       active;
	logic [3:0] cnt;
	logic [2:0] bitn;
	logic [7:0] sreg;
	logic [7:0] rsh;

	assign sh.busy = active;
	wire   half_end = (cnt == HALF_M1);

	// Two stages because the device output is asynchronous to clk_sys
	always_ff @(posedge clk_sys) begin
		so_meta <= sys_rst ? 1'b0 : serial_out;
		so_sync <= sys_rst ? 1'b0 : so_meta;
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			active       <= 1'b0;
			cnt          <= 4'h0;
			bitn         <= 3'h0;
			sreg         <= 8'h00;
			rsh          <= 8'h00;
			sh.rx        <= 8'h00;
			sh.done      <= 1'b0;
			serial_clock <= 1'b0;
			serial_in    <= 1'b0;
		end else if (!active) begin
			sh.done <= 1'b0;
			if (sh.start) begin
				active    <= 1'b1;
				sreg      <= sh.tx;
				serial_in <= sh.tx[7];
				cnt       <= 4'h0;
				bitn      <= 3'h0;
			end
		end else if (!half_end) begin
			cnt <= cnt + 4'h1;
		end else begin
			cnt <= 4'h0;
			if (!serial_clock) begin
				serial_clock <= 1'b1;
				rsh          <= {rsh[6:0], so_sync};
			end else begin
				serial_clock <= 1'b0;
				if (bitn == 3'h7) begin
					active  <= 1'b0;
					sh.done <= 1'b1;
					sh.rx   <= rsh;
				end else begin
					bitn      <= bitn + 3'h1;
					sreg      <= {sreg[6:0], 1'b0};
					serial_in <= sreg[6];
				end
			end
		end
	end

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	property p_data_stable;
		@(posedge clk_sys) disable iff (sys_rst)
		serial_clock |-> $stable(serial_in);
	endproperty
	a_data_stable: assert property (p_data_stable) else $error("data moved while clock high");

	property p_high_phase;
		@(posedge clk_sys) disable iff (sys_rst)
		$rose(serial_clock) |-> serial_clock [*4] ##1 !serial_clock;
	endproperty
	a_high_phase: assert property (p_high_phase) else $error("clock high phase wrong");

	property p_byte_time;
		@(posedge clk_sys) disable iff (sys_rst)
		$rose(active) |-> ##64 (sh.done && !active);
	endproperty
	a_byte_time: assert property (p_byte_time) else $error("byte not done in 64 cycles");
endmodule : spl_shifter
